// ---- inc/pin_timer_pkg.sv ----
// Shared constants and types of the pin-triggered up-counter.
// Assumes one 50 MHz clock that also serves as the pin filter clock.
package pin_timer_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int PRE_W = 8;

    // Register offsets (word index on the plain register port)
    localparam logic [ADDR_W-1:0] CTRL_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] CMP_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] CAP_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] CNT_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] STAT_OFS = 3'h4;

    // Control register field positions
    localparam int START_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int EDGE_BIT = 3;
    localparam int TSS_BIT = 4;
    localparam int ACAP_BIT = 5;
    localparam int WPOL_BIT = 6;
    localparam int SRC_LSB = 8;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] CMP_RST = 16'hffff;

    // Pin noise filter: pulses up to this many fc periods are dropped
    localparam int CLK_MHZ = 50;
    localparam int NOISE_PERIODS = 4;
    localparam int FILTER_CYC = NOISE_PERIODS + 1;
    localparam int FILT_W = 3;

    typedef enum logic [1:0] {
        MODE_TRIGGER,
        MODE_EVENT,
        MODE_WINDOW,
        MODE_SPARE
    } mode_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } run_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

endpackage

// ---- core/pin_noise_filter.sv ----
// Synchroniser and noise filter for the timer input pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
module pin_noise_filter (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_raw,
    output logic level
);
    import pin_timer_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic level;
        logic [FILT_W-1:0] cnt;
    } filt_state_t;

    filt_state_t q_reg;
    filt_state_t q_next;

    ////////////////////////////////////////////////////////////////////
    // A new level must hold for FILTER_CYC samples before it is taken
    always_comb begin
        q_next = q_reg;
        q_next.s1 = pin_raw;
        q_next.s2 = q_reg.s1;
        if (q_reg.s2 == q_reg.level) begin
            q_next.cnt = '0;
        end else if (q_reg.cnt == FILT_W'(FILTER_CYC - 1)) begin
            q_next.level = q_reg.s2;
            q_next.cnt = '0;
        end else begin
            q_next.cnt = q_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign level = q_reg.level;

    a_noise_reject: assert property (@(posedge clk) disable iff (rst)
        $changed(q_reg.level) |-> $past(q_reg.s2, 1) == q_reg.level
            && $past(q_reg.s2, 5) == q_reg.level)
        else $error("filtered level changed on a short pulse");

endmodule

// ---- core/pin_triggered_up_counter.sv ----
// Notes on behaviour
// - trigger mode idles until edge, then counts
// - edge select picks rising or falling trigger
// - stop-select 1: match clears, halts, interrupts
// - stop-select 1: opposite edge aborts silently
// - next trigger after halt restarts from zero
// - stop-select 0: match halts; opposite edge ignored
// - stop-select 0: retrigger while running ignored
// - pin pulses of four periods are dropped
// - event mode counts each selected pin edge
// - event match interrupts, clears, keeps counting
// - event match checked on opposite edge
// - auto-capture copies counter every source tick
// - window mode counts pin AND source clock
// - window polarity selects high or low counting
// - window match clears and raises window interrupt
//
// Up-counter timer steered by a filtered input pin, with a plain
// register port. Assumes the pin is asynchronous and the register
// master follows the one-cycle strobe protocol.
`timescale 1ns/100ps
module pin_triggered_up_counter (
    clk,
    rst,
    bus_req,
    rdata,
    timer_input_pin,
    timer_match_irq,
    window_match_irq
);
    import pin_timer_pkg::*;

    input wire logic clk;
    input wire logic rst;
    input wire pin_timer_pkg::bus_req_t bus_req;
    output logic [pin_timer_pkg::DATA_W-1:0] rdata;
    input wire logic timer_input_pin;
    output logic timer_match_irq;
    output logic window_match_irq;

    typedef struct packed {
        run_state_t state;
        logic pin_prev;
        logic [DATA_W-1:0] cnt;
        logic [DATA_W-1:0] cap;
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] cmp;
        logic [PRE_W-1:0] pre;
        logic [DATA_W-1:0] rdata;
        logic match_irq;
        logic win_irq;
    } state_t;

    state_t q_reg;
    state_t q_next;

    logic pin_level;
    logic rise;
    logic fall;
    logic trig_edge;
    logic opp_edge;
    logic tick;
    logic running;
    logic matched;
    logic win_open;
    mode_t mode;

    ////////////////////////////////////////////////////////////////////
    // Pin filter

    pin_noise_filter filter_inst (
        .clk(clk),
        .rst(rst),
        .pin_raw(timer_input_pin),
        .level(pin_level)
    );

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Prescaler mask: select n gives a tick every 2^(n+1) clocks
    function automatic logic [PRE_W-1:0] src_mask(input logic [1:0] sel);
        logic [PRE_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRE_W; i++) begin
            if (i <= int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [DATA_W-1:0] read_mux(input state_t s,
            input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] d;
        d = '0;
        if (a == CTRL_OFS) begin
            d = s.ctrl;
        end else if (a == CMP_OFS) begin
            d = s.cmp;
        end else if (a == CAP_OFS) begin
            d = s.cap;
        end else if (a == CNT_OFS) begin
            d = s.cnt;
        end else if (a == STAT_OFS) begin
            d = {{(DATA_W-2){1'b0}}, s.pin_prev, s.state == ST_RUN};
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decoded control and events

    always_comb begin
        mode = mode_t'(q_reg.ctrl[MODE_LSB +: 2]);
        running = q_reg.ctrl[START_BIT];
        rise = pin_level & ~q_reg.pin_prev;
        fall = ~pin_level & q_reg.pin_prev;
        trig_edge = q_reg.ctrl[EDGE_BIT] ? fall : rise;
        opp_edge = q_reg.ctrl[EDGE_BIT] ? rise : fall;
        tick = (q_reg.pre & src_mask(q_reg.ctrl[SRC_LSB +: 2]))
            == src_mask(q_reg.ctrl[SRC_LSB +: 2]);
        matched = q_reg.cnt == q_reg.cmp;
        // Window gate: pin level as seen through the polarity bit
        win_open = pin_level == q_reg.ctrl[WPOL_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        q_next = q_reg;
        q_next.pin_prev = pin_level;
        q_next.pre = q_reg.pre + 1'b1;
        q_next.match_irq = 1'b0;
        q_next.win_irq = 1'b0;
        q_next.rdata = '0;

        if (!running) begin
            // Pin edges are dropped and the count held at zero
            q_next.cnt = '0;
            q_next.state = ST_IDLE;
        end else begin
            case (mode)
                MODE_TRIGGER: begin
                    case (q_reg.state)
                        ST_IDLE: begin
                            if (trig_edge) begin
                                q_next.state = ST_RUN;
                                q_next.cnt = '0;
                            end
                        end
                        ST_RUN: begin
                            // A second trigger edge falls through here
                            if (q_reg.ctrl[TSS_BIT] && opp_edge) begin
                                q_next.cnt = '0;
                                q_next.state = ST_IDLE;
                            end else if (tick && matched) begin
                                q_next.cnt = '0;
                                q_next.state = ST_IDLE;
                                q_next.match_irq = 1'b1;
                            end else if (tick) begin
                                q_next.cnt = q_reg.cnt + 1'b1;
                            end
                        end
                        default: begin
                            q_next.state = ST_IDLE;
                        end
                    endcase
                end
                MODE_EVENT: begin
                    q_next.state = ST_RUN;
                    if (trig_edge) begin
                        q_next.cnt = q_reg.cnt + 1'b1;
                    end else if (opp_edge && matched) begin
                        q_next.cnt = '0;
                        q_next.match_irq = 1'b1;
                    end
                end
                MODE_WINDOW: begin
                    q_next.state = ST_RUN;
                    if (tick && win_open) begin
                        if (matched) begin
                            q_next.cnt = '0;
                            q_next.win_irq = 1'b1;
                        end else begin
                            q_next.cnt = q_reg.cnt + 1'b1;
                        end
                    end
                end
                default: begin
                    q_next.state = ST_IDLE;
                end
            endcase
        end

        // Capture follows the counter; software reads it while enabled
        if (running && q_reg.ctrl[ACAP_BIT] && tick) begin
            q_next.cap = q_reg.cnt;
        end

        // Register port
        if (bus_req.wr) begin
            if (bus_req.addr == CTRL_OFS) begin
                q_next.ctrl = bus_req.wdata;
            end else if (bus_req.addr == CMP_OFS) begin
                q_next.cmp = bus_req.wdata;
            end
        end
        if (bus_req.rd) begin
            q_next.rdata = read_mux(q_reg, bus_req.addr);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= '0;
            q_reg.state <= ST_IDLE;
            q_reg.ctrl <= CTRL_RST;
            q_reg.cmp <= CMP_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    assign rdata = q_reg.rdata;
    assign timer_match_irq = q_reg.match_irq;
    assign window_match_irq = q_reg.win_irq;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Stopped timer and register port
    a_stop_clears: assert property (
        !running |=> q_reg.cnt == '0 && q_reg.state == ST_IDLE)
        else $error("stopped timer did not clear");

    a_stop_silent: assert property (
        !running |=> !timer_match_irq && !window_match_irq)
        else $error("stopped timer raised an interrupt");

    a_cmp_write: assert property (
        bus_req.wr && bus_req.addr == CMP_OFS
        |=> q_reg.cmp == $past(bus_req.wdata))
        else $error("compare write not taken in full");

    // Trigger mode
    a_idle_holds: assert property (
        running && mode == MODE_TRIGGER && q_reg.state == ST_IDLE
            && !trig_edge && !bus_req.wr
        |=> q_reg.state == ST_IDLE && q_reg.cnt == $past(q_reg.cnt))
        else $error("idle trigger timer moved");

    a_wrong_edge: assert property (
        running && mode == MODE_TRIGGER && q_reg.state == ST_IDLE
            && opp_edge
        |=> q_reg.state == ST_IDLE)
        else $error("opposite edge started the count");

    a_trigger_start: assert property (
        running && mode == MODE_TRIGGER && q_reg.state == ST_IDLE
            && trig_edge
        |=> q_reg.state == ST_RUN && q_reg.cnt == '0)
        else $error("trigger edge did not start from zero");

    a_match_halt: assert property (
        running && mode == MODE_TRIGGER && q_reg.state == ST_RUN && tick
            && matched && !(q_reg.ctrl[TSS_BIT] && opp_edge)
        |=> timer_match_irq && q_reg.cnt == '0 && q_reg.state == ST_IDLE
            ##1 !timer_match_irq)
        else $error("trigger match did not halt");

    // A mode change in the same cycle may legally start a second pulse
    a_irq_pulse: assert property (
        timer_match_irq && $stable(q_reg.ctrl) |=> !timer_match_irq)
        else $error("match interrupt longer than one cycle");

    a_abort_silent: assert property (
        running && mode == MODE_TRIGGER && q_reg.state == ST_RUN
            && q_reg.ctrl[TSS_BIT] && opp_edge
        |=> !timer_match_irq && q_reg.state == ST_IDLE
            && q_reg.cnt == '0)
        else $error("opposite edge abort misbehaved");

    a_opp_ignored: assert property (
        running && mode == MODE_TRIGGER && q_reg.state == ST_RUN
            && !q_reg.ctrl[TSS_BIT] && opp_edge
        |=> q_reg.state == ST_RUN || timer_match_irq)
        else $error("opposite edge stopped the count");

    a_retrig_ignored: assert property (
        running && mode == MODE_TRIGGER && q_reg.state == ST_RUN
            && !q_reg.ctrl[TSS_BIT] && !tick && !bus_req.wr
        |=> q_reg.state == ST_RUN && $stable(q_reg.cnt))
        else $error("running count disturbed by pin");

    // Event mode and capture
    a_event_count: assert property (
        running && mode == MODE_EVENT && trig_edge
        |=> q_reg.cnt == $past(q_reg.cnt) + 16'h0001)
        else $error("event edge not counted");

    a_event_run: assert property (
        running && mode == MODE_EVENT && !trig_edge
            && !(opp_edge && matched)
        |=> $stable(q_reg.cnt))
        else $error("event count moved without an edge");

    a_event_match: assert property (
        running && mode == MODE_EVENT && opp_edge && matched
        |=> timer_match_irq && q_reg.cnt == '0 && q_reg.state == ST_RUN)
        else $error("event match not on opposite edge");

    a_capture_copy: assert property (
        running && q_reg.ctrl[ACAP_BIT] && tick
        |=> q_reg.cap == $past(q_reg.cnt))
        else $error("auto capture missed a tick");

    a_cap_hold: assert property (
        !(running && q_reg.ctrl[ACAP_BIT] && tick) |=> $stable(q_reg.cap))
        else $error("capture changed off a source tick");

    // Window mode
    a_window_count: assert property (
        running && mode == MODE_WINDOW && tick && !matched
        |=> q_reg.cnt == $past(q_reg.cnt) + ($past(win_open) ? 16'h0001
            : 16'h0000))
        else $error("window count wrong");

    a_window_closed: assert property (
        running && mode == MODE_WINDOW && !win_open |=> $stable(q_reg.cnt))
        else $error("window count moved while closed");

    a_window_match: assert property (
        running && mode == MODE_WINDOW && tick && win_open && matched
        |=> window_match_irq && !timer_match_irq && q_reg.cnt == '0)
        else $error("window match not flagged");

    a_window_only: assert property (
        mode != MODE_WINDOW |=> !window_match_irq)
        else $error("window interrupt outside window mode");

endmodule

// ---- tb/pin_source.sv ----
// Behavioural pulse source that drives the timer input pin.
// Assumes the bench commands every level change.
`timescale 1ns/100ps
module pin_source (
    input wire logic clk,
    output logic pin
);
    initial pin = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Each level is held long enough for the pin filter to accept it.
    task automatic hold(input logic lvl, input int cyc);
        @(posedge clk);
        pin <= lvl;
        repeat ((cyc < 12) ? 11 : cyc - 1) @(posedge clk);
    endtask

    // Short pulse, only when a test asks for noise on purpose
    task automatic glitch(input int cyc);
        @(posedge clk);
        pin <= ~pin;
        repeat (cyc) @(posedge clk);
        pin <= ~pin;
    endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the pin-triggered up-counter.
// Assumes source select 0 (a tick every two clocks) unless a test sets it.
`timescale 1ns/100ps
module tb;
    import pin_timer_pkg::*;
    logic clk, rst, pin, tmi, wmi;
    bus_req_t bus_req;
    logic [DATA_W-1:0] rdata, v, c;
    int n_mismatch, n_tests, cyc, n_tmi, n_wmi, t0, w0, k;

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

    pin_triggered_up_counter pin_triggered_up_counter_i (.clk(clk),
        .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .timer_input_pin(pin), .timer_match_irq(tmi),
        .window_match_irq(wmi));
    pin_source pin_source_i (.clk(clk), .pin(pin));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulses are tallied here so a one-cycle irq is never missed
    always @(posedge clk) begin
        cyc++;
        if (tmi === 1'b1) n_tmi++;
        if (wmi === 1'b1) n_wmi++;
        if (cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] ctrl(mode_t m, logic e, logic t,
            logic a, logic p);
        ctrl = 16'h0001 | (16'(m) << MODE_LSB) | (16'(e) << EDGE_BIT) |
            (16'(t) << TSS_BIT) | (16'(a) << ACAP_BIT) | (16'(p) << WPOL_BIT);
    endfunction

    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req <= '0;
    endtask

    task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        bus_req <= '0;
        #1 d = rdata;
    endtask

    task automatic chk_rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        rd(a, v);
        `CHK(v, e)
    endtask

    task automatic stop();
        wr(CTRL_OFS, 16'h0000);
        chk_rd(CNT_OFS, 16'h0000);
    endtask

    task automatic wait_tmi(int lim);
        for (int i = 0; i < lim && n_tmi == t0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    task automatic done(string s);
        $display("test %s done", s);
    endtask

    task automatic end_sim();
        $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        bus_req = '0;
        void'($urandom(34));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk_rd(CTRL_OFS, CTRL_RST);
        chk_rd(CMP_OFS, CMP_RST);
        wr(CNT_OFS, 16'h1234);
        chk_rd(CNT_OFS, 16'h0000);
        chk_rd(3'h7, 16'h0000);
        c = 16'($urandom);
        wr(CMP_OFS, c);
        chk_rd(CMP_OFS, c);
        done("registers");

        // Trigger, stop select 1: random match value
        wr(CMP_OFS, 16'(4 + $urandom % 8));
        wr(CTRL_OFS, ctrl(MODE_TRIGGER, 1'b0, 1'b1, 1'b0, 1'b0));
        t0 = n_tmi;
        pin_source_i.hold(1'b1, 12);
        wait_tmi(200);
        `CHK(n_tmi - t0, 1)
        chk_rd(CNT_OFS, 16'h0000);
        chk_rd(STAT_OFS, 16'h0002);
        pin_source_i.hold(1'b0, 12);
        // Abort by opposite edge, then restart
        wr(CMP_OFS, 16'h0200);
        t0 = n_tmi;
        pin_source_i.hold(1'b1, 12);
        chk_rd(STAT_OFS, 16'h0003);
        pin_source_i.hold(1'b0, 20);
        chk_rd(STAT_OFS, 16'h0000);
        chk_rd(CNT_OFS, 16'h0000);
        `CHK(n_tmi - t0, 0)
        pin_source_i.hold(1'b1, 20);
        rd(CNT_OFS, v);
        `CHK(v > 0 && v < 12, 1'b1)
        pin_source_i.hold(1'b0, 12);
        stop();
        done("trigger stop");

        // Falling edge selected: rising must not start
        wr(CTRL_OFS, ctrl(MODE_TRIGGER, 1'b1, 1'b1, 1'b0, 1'b0));
        pin_source_i.hold(1'b1, 20);
        chk_rd(STAT_OFS, 16'h0002);
        pin_source_i.hold(1'b0, 20);
        chk_rd(STAT_OFS, 16'h0001);
        stop();
        done("edge select");

        // Stop select 0: opposite edge and retrigger ignored
        wr(CMP_OFS, 16'h0060);
        wr(CTRL_OFS, ctrl(MODE_TRIGGER, 1'b0, 1'b0, 1'b0, 1'b0));
        t0 = n_tmi;
        pin_source_i.hold(1'b1, 20);
        pin_source_i.hold(1'b0, 20);
        chk_rd(STAT_OFS, 16'h0001);
        rd(CNT_OFS, c);
        pin_source_i.hold(1'b1, 20);
        rd(CNT_OFS, v);
        `CHK(v > c, 1'b1)
        wait_tmi(400);
        `CHK(n_tmi - t0, 1)
        chk_rd(STAT_OFS, 16'h0002);
        pin_source_i.hold(1'b0, 12);
        stop();
        done("trigger start");

        // Event counting with noise rejection and auto-capture
        wr(CMP_OFS, 16'hffff);
        wr(CTRL_OFS, ctrl(MODE_EVENT, 1'b0, 1'b0, 1'b1, 1'b0));
        pin_source_i.glitch(4);
        repeat (12) @(posedge clk);
        chk_rd(CNT_OFS, 16'h0000);
        k = 1 + $urandom % 6;
        repeat (k) begin
            pin_source_i.hold(1'b1, 12 + $urandom % 4);
            pin_source_i.hold(1'b0, 12);
        end
        chk_rd(CNT_OFS, 16'(k));
        chk_rd(CAP_OFS, 16'(k));
        stop();
        done("event count");

        // Event match on falling count edge, decided on rising edge
        wr(CMP_OFS, 16'h0003);
        wr(CTRL_OFS, ctrl(MODE_EVENT, 1'b1, 1'b0, 1'b0, 1'b0));
        t0 = n_tmi;
        repeat (3) begin
            pin_source_i.hold(1'b1, 12);
            pin_source_i.hold(1'b0, 12);
        end
        chk_rd(CNT_OFS, 16'h0003);
        `CHK(n_tmi - t0, 0)
        pin_source_i.hold(1'b1, 12);
        `CHK(n_tmi - t0, 1)
        chk_rd(CNT_OFS, 16'h0000);
        pin_source_i.hold(1'b0, 12);
        chk_rd(CNT_OFS, 16'h0001);
        stop();
        done("event match");

        // Window mode, both polarities; about 20 ticks per 40 clocks
        wr(CMP_OFS, 16'hffff);
        for (int p = 0; p < 2; p++) begin
            // Close the window before the start bit, or it counts at once
            pin_source_i.hold(1'(~p), 20);
            wr(CTRL_OFS, ctrl(MODE_WINDOW, 1'b0, 1'b0, 1'b0, 1'(p)));
            repeat (10) @(posedge clk);
            chk_rd(CNT_OFS, 16'h0000);
            pin_source_i.hold(1'(p), 40);
            rd(CNT_OFS, c);
            `CHK(c >= 16 && c <= 24, 1'b1)
            pin_source_i.hold(1'(~p), 20);
            rd(CNT_OFS, v);
            `CHK(v - c <= 8, 1'b1)
            stop();
        end
        wr(CMP_OFS, 16'h0004);
        wr(CTRL_OFS, ctrl(MODE_WINDOW, 1'b0, 1'b0, 1'b0, 1'b1));
        t0 = n_tmi;
        w0 = n_wmi;
        pin_source_i.hold(1'b1, 30);
        pin_source_i.hold(1'b0, 20);
        `CHK(n_wmi - w0 >= 2, 1'b1)
        `CHK(n_tmi - t0, 0)
        stop();
        done("window");

        // Source select 1: one tick every four clocks
        wr(CMP_OFS, 16'hffff);
        wr(CTRL_OFS, ctrl(MODE_WINDOW, 1'b0, 1'b0, 1'b0, 1'b1)
            | (16'h0001 << SRC_LSB));
        pin_source_i.hold(1'b1, 40);
        rd(CNT_OFS, c);
        `CHK(c >= 6 && c <= 10, 1'b1)
        pin_source_i.hold(1'b0, 12);
        stop();
        done("source select");
        end_sim();
    end
endmodule
